// ==== hdl/phc_consts.svh ====
// Purpose: Offsets, field positions and reset values of the highway port.
// Assumes: Byte addresses on a 32-bit classic Wishbone bus.
// Notes:   Definitions only.
`ifndef PHC_CONSTS_SVH
`define PHC_CONSTS_SVH
// ****************************************************************
// Register byte addresses.
// ****************************************************************
`define PHC_ADR_OFD 8'h00
`define PHC_ADR_OFU 8'h04
`define PHC_ADR_CSR 8'h08
`define PHC_ADR_HMR 8'h0C
`define PHC_ADR_OMR 8'h10
`define PHC_ADR_STS 8'h14
`define PHC_ADR_BPF 8'h18
// ****************************************************************
// Reset values.
// ****************************************************************
`define PHC_RST_BYTE 8'h00
`define PHC_RST_BPF  10'h100
// ****************************************************************
// Field positions.
// ****************************************************************
`define PHC_CSR_URE     0
`define PHC_CSR_OFU_LSB 2
`define PHC_CSR_DRE     4
`define PHC_CSR_OFD_LSB 6
`define PHC_HMR_PSM     2
`define PHC_HMR_ALT_INPUT_SEL_LO    3
`define PHC_HMR_ALT_INPUT_SEL_HI    4
`define PHC_HMR_COMPARE_ENABLE_LO    5
`define PHC_HMR_COMPARE_ENABLE_HI    6
`define PHC_OMR_PTL     4
`define PHC_OMR_PSB     5
// ****************************************************************
// Software offset constants per mode, downstream and upstream.
// ****************************************************************
`define PHC_DN_K0 17
`define PHC_DN_K1 33
`define PHC_DN_K2 65
`define PHC_UP_K0 23
`define PHC_UP_K1 47
`define PHC_UP_K2 95
`endif

// ==== hdl/phc_pkg.sv ====
// Purpose: Types shared by the highway port.
// Assumes: Nothing.
// Notes:   Constants live in phc_consts.svh.
package phc_pkg;
  typedef enum logic [1:0] {
    PHC_MODE0 = 2'h0,
    PHC_MODE1 = 2'h1,
    PHC_MODE2 = 2'h2,
    PHC_MODE3 = 2'h3
  } phc_mode_e;
  typedef struct packed {
    logic [7:0] ofd;
    logic [7:0] ofu;
    logic [7:0] csr;
    logic [7:0] hmr;
    logic [7:0] omr;
    logic [9:0] bits_per_frame;
  } phc_cfg_s;
  typedef struct packed {
    logic       bclk;
    logic       fs;
    logic [3:0] rx;
  } phc_pins_s;
endpackage : phc_pkg

// ==== hdl/phc_top.sv ====
// Purpose: Highway port control with frame offsets and line selection.
// Assumes: Single clock rate; pins are asynchronous to clk_sys.
// Notes:   Registers on classic Wishbone, one wait state.
//
// Added by the designer: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ps
`include "phc_consts.svh"
// Behaviour
// - Downstream offset is (marked bit minus 17/33/65 plus frame) mod frame.
// - Upstream offset is (marked bit plus 23/47/95) mod frame.
// - Each logical transmit port sits on one fixed physical pin.
// - Mode 1: lines 0/1 and 2/3 feed logical ports by select bits.
// - Mode 2: select high bit picks line 2 or 3; low ignored.
// - Modes 1 and 2 drive select bits on control pins 1 and 3.
// - Pins 1 and 3 float in modes 1, 2; port 2 unused in 2.
// - Compare enables check lines 0/1 and 2/3 for mismatch.
// - Comparison works in every mode, whatever line is selected.
// - Standby floats all transmit pins, control pins read one except 1 and 3 in modes 1, 2.
// - Standby keeps receiving, comparing and counting.
// - Active pins send upstream data unless slot marked tristate.
// - Test loop routes transmit lines to receivers, ignoring pins.
// - Transmit pins keep driving during the test loop.
// - Sync sampled on falling clock edge at 0, rising at 1.
// - Transmit on rising edge when select is 1, else falling.
// - Receive on falling edge when select is 0, else rising.
module phc_top (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        ce,
  input  wire logic        wb_cyc,
  input  wire logic        wb_stb,
  input  wire logic        wb_we,
  input  wire logic [7:0]  wb_adr,
  input  wire logic [3:0]  wb_sel,
  input  wire logic [31:0] wb_dat_w,
  output logic      [31:0] wb_dat_r,
  output logic             wb_ack,
  input  wire logic        highway_bit_clock,
  input  wire logic        highway_frame_sync,
  input  wire logic [3:0]  rxd,
  output logic      [3:0]  txd,
  output logic      [3:0]  txd_oe,
  output logic      [3:0]  output_tristate_ctrl_n,
  input  wire logic [3:0]  up_data,
  input  wire logic [3:0]  up_tristate,
  output logic      [3:0]  rx_data,
  output logic             rx_valid,
  output logic             frame_start,
  output logic      [9:0]  up_bit_num,
  output logic      [9:0]  down_bit_num
);
  // ****************************************************************
  // Helpers.
  // ****************************************************************
  function automatic logic [9:0] phc_offset(input logic [7:0] hi,
                                            input logic [1:0] lo,
                                            input logic [1:0] md);
    case (md)
      2'h0:    phc_offset = {hi, 2'h0};
      2'h1:    phc_offset = {hi, lo[1], 1'b0};
      2'h2:    phc_offset = {hi, lo};
      default: phc_offset = {hi, 2'h0};
    endcase
  endfunction : phc_offset

  function automatic logic [7:0] phc_word(input logic [7:0] a);
    phc_word = {a[7:2], 2'b00};
  endfunction : phc_word

  function automatic logic [9:0] phc_step(input logic [9:0] c,
                                          input logic [9:0] n);
    phc_step = (c == n - 10'h001) ? 10'h000 : c + 10'h001;
  endfunction : phc_step

  phc_pkg::phc_cfg_s  cfg_q, cfg_d;
  phc_pkg::phc_pins_s sy1_q, sy2_q;
  phc_pkg::phc_mode_e mode;
  logic [1:0]  flg_q, flg_d, mis_set;
  logic        ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic        bclk_q, fs_q, fs_d, rise, fall, fs_edge, fstart;
  logic        tx_edge, rx_edge, sb, loop, alt_input_sel_lo, alt_input_sel_hi;
  logic [9:0]  ofd_full, ofu_full, dcnt_q, dcnt_d, ucnt_q, ucnt_d;
  logic [3:0]  src, sel_rx, port_ok, tri_q, tri_d;
  logic [3:0]  txd_q, txd_d, oe_q, oe_d, tsc_q, tsc_d, rx_q, rx_d;
  logic        rxv_q, fst_q;

  assign mode = phc_pkg::phc_mode_e'(cfg_q.hmr[1:0]);
  assign sb   = cfg_q.omr[`PHC_OMR_PSB];
  assign loop = cfg_q.omr[`PHC_OMR_PTL];
  assign alt_input_sel_lo = cfg_q.hmr[`PHC_HMR_ALT_INPUT_SEL_LO];
  assign alt_input_sel_hi = cfg_q.hmr[`PHC_HMR_ALT_INPUT_SEL_HI];
  assign ofd_full = phc_offset(cfg_q.ofd,
                      cfg_q.csr[`PHC_CSR_OFD_LSB+:2], cfg_q.hmr[1:0]);
  assign ofu_full = phc_offset(cfg_q.ofu,
                      cfg_q.csr[`PHC_CSR_OFU_LSB+:2], cfg_q.hmr[1:0]);

  // ****************************************************************
  // Register file on the bus.
  // ****************************************************************
  always_comb
  begin
    cfg_d  = cfg_q;
    ack_d  = wb_cyc & wb_stb & ~ack_q;
    rdat_d = 32'h0000_0000;
    flg_d  = flg_q | mis_set;
    if (ack_d)
    begin
      case (phc_word(wb_adr))
        `PHC_ADR_OFD: rdat_d[7:0] = cfg_q.ofd;
        `PHC_ADR_OFU: rdat_d[7:0] = cfg_q.ofu;
        `PHC_ADR_CSR: rdat_d[7:0] = cfg_q.csr;
        `PHC_ADR_HMR: rdat_d[7:0] = cfg_q.hmr;
        `PHC_ADR_OMR: rdat_d[7:0] = cfg_q.omr;
        `PHC_ADR_STS: rdat_d[1:0] = flg_q;
        `PHC_ADR_BPF: rdat_d[9:0] = cfg_q.bits_per_frame;
        default:      rdat_d = 32'h0000_0000;
      endcase
      if (wb_we && wb_sel[0])
      begin
        case (phc_word(wb_adr))
          `PHC_ADR_OFD: cfg_d.ofd = wb_dat_w[7:0];
          `PHC_ADR_OFU: cfg_d.ofu = wb_dat_w[7:0];
          `PHC_ADR_CSR: cfg_d.csr = wb_dat_w[7:0];
          `PHC_ADR_HMR: cfg_d.hmr = wb_dat_w[7:0];
          `PHC_ADR_OMR: cfg_d.omr = wb_dat_w[7:0];
          `PHC_ADR_STS: flg_d = (flg_q & ~wb_dat_w[1:0]) | mis_set;
          `PHC_ADR_BPF: cfg_d.bits_per_frame[7:0] = wb_dat_w[7:0];
          default:      cfg_d = cfg_q;
        endcase
      end
      if (wb_we && wb_sel[1] && (phc_word(wb_adr) == `PHC_ADR_BPF))
      begin
        cfg_d.bits_per_frame[9:8] = wb_dat_w[9:8];
      end
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      cfg_q  <= {{5{`PHC_RST_BYTE}}, `PHC_RST_BPF};
      flg_q  <= 2'h0;
      ack_q  <= 1'b0;
      rdat_q <= 32'h0000_0000;
    end
    else if (ce)
    begin
      cfg_q  <= cfg_d;
      flg_q  <= flg_d;
      ack_q  <= ack_d;
      rdat_q <= rdat_d;
    end
  end

  // ****************************************************************
  // Highway link.
  // ****************************************************************
  always_comb
  begin
    rise    = sy2_q.bclk & ~bclk_q;
    fall    = ~sy2_q.bclk & bclk_q;
    fs_edge = cfg_q.hmr[`PHC_HMR_PSM] ? rise : fall;
    fstart  = fs_edge & sy2_q.fs & ~fs_q;
    fs_d    = fs_edge ? sy2_q.fs : fs_q;
    tx_edge = cfg_q.csr[`PHC_CSR_URE] ? rise : fall;
    rx_edge = cfg_q.csr[`PHC_CSR_DRE] ? rise : fall;
    src     = loop ? txd_q : sy2_q.rx;
    // Comparison looks at physical lines, not the selection.
    mis_set = {2{rx_edge}} & {cfg_q.hmr[`PHC_HMR_COMPARE_ENABLE_HI] & (src[2] ^ src[3]),
               cfg_q.hmr[`PHC_HMR_COMPARE_ENABLE_LO] & (src[0] ^ src[1])};
    case (mode)
      phc_pkg::PHC_MODE1:
      begin
        sel_rx  = {2'h0, alt_input_sel_hi ? src[2] : src[3],
                   alt_input_sel_lo ? src[0] : src[1]};
        port_ok = 4'h5;
      end
      phc_pkg::PHC_MODE2:
      begin
        sel_rx  = {3'h0, alt_input_sel_hi ? src[2] : src[3]};
        port_ok = 4'h1;
      end
      default:
      begin
        sel_rx  = src;
        port_ok = 4'hF;
      end
    endcase
    // Standby leaves the receive path running.
    rx_d   = rx_edge ? sel_rx : rx_q;
    dcnt_d = fstart ? ofd_full :
             (rx_edge ? phc_step(dcnt_q, cfg_q.bits_per_frame) : dcnt_q);
    ucnt_d = fstart ? ofu_full :
             (tx_edge ? phc_step(ucnt_q, cfg_q.bits_per_frame) : ucnt_q);
    txd_d  = tx_edge ? up_data : txd_q;
    tri_d  = tx_edge ? up_tristate : tri_q;
    oe_d   = {4{sb}} & ~tri_d & port_ok;
    tsc_d  = ~oe_d;
    if (mode == phc_pkg::PHC_MODE1 || mode == phc_pkg::PHC_MODE2)
    begin
      tsc_d[1] = alt_input_sel_lo;
      tsc_d[3] = alt_input_sel_hi;
    end
    if (mode == phc_pkg::PHC_MODE2)
    begin
      tsc_d[2] = 1'b1;
    end
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      sy1_q  <= '0;
      sy2_q  <= '0;
      bclk_q <= 1'b0;
      fs_q   <= 1'b0;
      dcnt_q <= 10'h000;
      ucnt_q <= 10'h000;
      txd_q  <= 4'h0;
      tri_q  <= 4'h0;
      oe_q   <= 4'h0;
      tsc_q  <= 4'hF;
      rx_q   <= 4'h0;
      rxv_q  <= 1'b0;
      fst_q  <= 1'b0;
    end
    else if (ce)
    begin
      sy1_q  <= {highway_bit_clock, highway_frame_sync, rxd};
      sy2_q  <= sy1_q;
      bclk_q <= sy2_q.bclk;
      fs_q   <= fs_d;
      dcnt_q <= dcnt_d;
      ucnt_q <= ucnt_d;
      txd_q  <= txd_d;
      tri_q  <= tri_d;
      oe_q   <= oe_d;
      tsc_q  <= tsc_d;
      rx_q   <= rx_d;
      rxv_q  <= rx_edge;
      fst_q  <= fstart;
    end
  end

  assign wb_ack                 = ack_q;
  assign wb_dat_r               = rdat_q;
  assign txd                    = txd_q;
  assign txd_oe                 = oe_q;
  assign output_tristate_ctrl_n = tsc_q;
  assign rx_data                = rx_q;
  assign rx_valid               = rxv_q;
  assign frame_start            = fst_q;
  assign down_bit_num           = dcnt_q;
  assign up_bit_num             = ucnt_q;

  // ****************************************************************
  // Checks.
  // ****************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);

  a_standby_float: assert property (
    (ce && !sb) |=> (txd_oe == 4'h0))
    else $error("Transmit pin driven in standby.");
  a_standby_ctrl: assert property (
    (ce && !sb && mode == phc_pkg::PHC_MODE0) |=>
    (output_tristate_ctrl_n == 4'hF))
    else $error("Control pin active in standby.");
  a_select_out: assert property (
    (ce && (mode == phc_pkg::PHC_MODE1 || mode == phc_pkg::PHC_MODE2)) |=>
    (output_tristate_ctrl_n[1] == $past(alt_input_sel_lo) &&
     output_tristate_ctrl_n[3] == $past(alt_input_sel_hi)))
    else $error("Select bits not on control pins.");
  a_odd_float: assert property (
    (ce && (mode == phc_pkg::PHC_MODE1 || mode == phc_pkg::PHC_MODE2)) |=>
    (!txd_oe[1] && !txd_oe[3]))
    else $error("Odd transmit pin driven in modes 1 or 2.");
  a_mismatch_set: assert property (
    (ce && mis_set[0]) |=> ##[0:2] (flg_q[0] || !ce))
    else $error("Mismatch flag not set.");
  a_rx_select: assert property (
    (ce && rx_edge && mode == phc_pkg::PHC_MODE1) |=>
    (rx_data[0] == $past(alt_input_sel_lo ? src[0] : src[1])))
    else $error("Wrong line picked for port 0.");
  a_tx_slot: assert property (
    (ce && tx_edge && sb && !up_tristate[0]) |=>
    (txd[0] == $past(up_data[0]) && txd_oe[0]))
    else $error("Upstream bit not driven.");
  a_down_load: assert property (
    (ce && fstart) |=> (down_bit_num == $past(ofd_full) && frame_start))
    else $error("Downstream offset not loaded at frame start.");
  a_loop_route: assert property (
    (ce && loop && rx_edge && mode == phc_pkg::PHC_MODE0) |=>
    (rx_data == $past(txd_q)))
    else $error("Test loop data not routed back.");
endmodule : phc_top

// ==== sim/phc_highway_model.sv ====
// Purpose: Far side of the highway: bit clock, frame sync, receive lines.
// Assumes: Single clock rate, one bit per bit clock.
// Notes:   The bit clock runs free, as a highway clock does.
`timescale 1ns/1ps
// ****************************************************************
// Highway source.
// ****************************************************************
module phc_highway_model #(
  parameter int BITS = 32
) (
  input  wire logic [3:0] rx_pat,
  output logic            bit_clock,
  output logic            frame_sync,
  output logic [3:0]      rx_lines
);
  int cnt;

  initial
  begin
    bit_clock = 1'b0;
    frame_sync = 1'b0;
    rx_lines = 4'h0;
    cnt = 0;
    #37;
    forever #80 bit_clock = ~bit_clock;
  end

  // Sync and data change on the rising edge, so falling sampling is safe.
  always @(posedge bit_clock)
  begin
    cnt <= (cnt == BITS - 1) ? 0 : cnt + 1;
    frame_sync <= (cnt == BITS - 1);
    rx_lines <= rx_pat;
  end
endmodule : phc_highway_model

// ==== sim/phc_top_tb_top.sv ====
// Purpose: Self-checking bench for the highway port control.
// Assumes: The highway model drives clock, sync and receive lines.
// Notes:   Bus reads are checked from a queue of expected words.
`timescale 1ns/1ps
`include "phc_consts.svh"
module phc_top_tb_top;
  logic        clk_sys, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack;
  logic        rx_valid, bclk, fs;
  logic [7:0]  wb_adr;
  logic [3:0]  wb_sel, rxd, txd, txd_oe, ctrl_n, up_data, up_tri;
  logic [3:0]  rx_data, rx_pat, v;
  logic        fst_p, fs_on;
  logic [9:0]  dnum, unum, exp_dn, exp_up;
  logic [31:0] wb_dat_w, wb_dat_r, exp_q[$];
  int          seed = 92862;
  int          miscompares = 0;
  int          samples_checked = 0;
  int          bits_per_frame;

  phc_top phc_top_i (.clk_sys(clk_sys), .sys_rst(sys_rst), .ce(1'b1),
    .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
    .wb_ack(wb_ack), .highway_bit_clock(bclk), .highway_frame_sync(fs),
    .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .output_tristate_ctrl_n(ctrl_n),
    .up_data(up_data), .up_tristate(up_tri), .rx_data(rx_data),
    .rx_valid(rx_valid), .frame_start(fst_p), .up_bit_num(unum),
    .down_bit_num(dnum));

  phc_highway_model phc_highway_model_i (.rx_pat(rx_pat),
    .bit_clock(bclk), .frame_sync(fs), .rx_lines(rxd));

  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
// ****************************************************************
// Checking and bus tasks.
// ****************************************************************
  task automatic fail(input string m);
    miscompares++;
    $display("CHECK FAILED %0t %s", $time, m);
  endtask : fail

  task automatic chk(input logic [3:0] got, input logic [3:0] exp);
    samples_checked++;
    if (got !== exp) fail($sformatf("pins %h expected %h", got, exp));
  endtask : chk

  task automatic bus(input logic [7:0] a, input logic we,
                     input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat_w <= d;
    @(posedge clk_sys);
    while (wb_ack !== 1'b1 && n < 50)
    begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 50) fail("bus timeout");
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_sys);
  endtask : bus

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(a, 1'b0, 32'h0);
  endtask : rd

  task automatic bits(input int n);
    int t;
    t = 0;
    while (n > 0 && t < 4000)
    begin
      @(posedge clk_sys);
      t++;
      if (rx_valid === 1'b1) n--;
    end
    if (t >= 4000) fail("no receive strobe");
  endtask : bits

  task automatic stop_test;
    if (miscompares == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : stop_test

  always @(posedge clk_sys)
    if (wb_ack === 1'b1 && wb_we === 1'b0)
    begin
      samples_checked++;
      if (exp_q.size() == 0) fail("read not expected");
      else if (wb_dat_r !== exp_q.pop_front()) fail("read data wrong");
    end

  always @(posedge clk_sys)
    if (fs_on === 1'b1 && fst_p === 1'b1)
    begin
      samples_checked += 2;
      if (dnum !== exp_dn) fail("downstream offset wrong");
      if (unum !== exp_up) fail("upstream offset wrong");
    end

  initial
  begin
    #100000;
    miscompares++;
    stop_test();
  end
// ****************************************************************
// Scenarios.
// ****************************************************************
  initial
  begin
    sys_rst = 1'b1;
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_dat_w} = '0;
    wb_sel = 4'hF;
    {up_data, up_tri, rx_pat, v} = '0;
    fs_on = 1'b0;
    exp_dn = 10'h000;
    exp_up = 10'h000;
    repeat (5) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    rd(`PHC_ADR_BPF, 32'h100);
    rd(8'h1C, 32'h0);
    bits_per_frame = 32;
    bus(`PHC_ADR_BPF, 1'b1, 32'(bits_per_frame));
    bus(`PHC_ADR_OFD, 1'b1, 32'((2 - `PHC_DN_K0 + bits_per_frame) % bits_per_frame));
    rd(`PHC_ADR_OFD, 32'((2 - `PHC_DN_K0 + bits_per_frame) % bits_per_frame));
    bus(`PHC_ADR_OFU, 1'b1, 32'((2 + `PHC_UP_K0) % bits_per_frame));
    rd(`PHC_ADR_OFU, 32'((2 + `PHC_UP_K0) % bits_per_frame));
    exp_dn = 10'(((2 - `PHC_DN_K0 + bits_per_frame) % bits_per_frame) << 2);
    exp_up = 10'(((2 + `PHC_UP_K0) % bits_per_frame) << 2);
    fs_on = 1'b1;
    rx_pat <= 4'($random(seed));
    up_data <= 4'($random(seed));
    bits(3);
    chk(txd_oe, 4'h0);
    chk(ctrl_n, 4'hF);
    chk(rx_data, rx_pat);
    bus(`PHC_ADR_OMR, 1'b1, 32'h20);
    up_tri <= 4'($random(seed));
    bits(3);
    chk(txd_oe, ~up_tri);
    chk(txd & txd_oe, up_data & txd_oe);
    up_tri <= 4'h0;
    for (int s = 0; s < 4; s++)
    begin
      bus(`PHC_ADR_HMR, 1'b1, 32'(1 + (s << 3)));
      rx_pat <= 4'($random(seed));
      bits(3);
      chk({2'h0, rx_data[1:0]}, {2'h0, s[1] ? rx_pat[2] : rx_pat[3],
          s[0] ? rx_pat[0] : rx_pat[1]});
      chk({txd_oe[3], txd_oe[1], txd_oe[2], txd_oe[0]},
          4'h3);
      chk({2'h0, ctrl_n[3], ctrl_n[1]}, 4'(s));
      chk({2'h0, txd[2], txd[0]},
          {2'h0, up_data[2], up_data[0]});
      bus(`PHC_ADR_HMR, 1'b1, 32'(2 + (s << 3)));
      bits(3);
      chk({3'h0, rx_data[0]},
          {3'h0, s[1] ? rx_pat[2] : rx_pat[3]});
      chk({2'h0, txd_oe[3], txd_oe[1]}, 4'h0);
    end
    bus(`PHC_ADR_HMR, 1'b1, 32'h21);
    rx_pat <= 4'h6;
    bits(3);
    rd(`PHC_ADR_STS, 32'h1);
    rx_pat <= 4'h0;
    bits(3);
    bus(`PHC_ADR_STS, 1'b1, 32'h3);
    rd(`PHC_ADR_STS, 32'h0);
    bus(`PHC_ADR_HMR, 1'b1, 32'h40);
    rx_pat <= 4'h6;
    bits(3);
    rd(`PHC_ADR_STS, 32'h2);
    bus(`PHC_ADR_CSR, 1'b1, 32'h11);
    rx_pat <= 4'($random(seed));
    bits(3);
    chk(rx_data, rx_pat);
    chk(txd & txd_oe, up_data & txd_oe);
    bus(`PHC_ADR_CSR, 1'b1, 32'h0);
    bus(`PHC_ADR_HMR, 1'b1, 32'h0);
    bus(`PHC_ADR_OMR, 1'b1, 32'h30);
    v = 4'($random(seed));
    up_data <= v;
    rx_pat <= ~v;
    bits(4);
    chk(rx_data, v);
    chk(txd_oe, 4'hF);
    stop_test();
  end
endmodule : phc_top_tb_top
